// File: pkg/dch_pkg.sv
// constants and types shared by the dram controller files
package dch_pkg;

   // ---------------------------------------------------------------
   // clock and timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int T_RCD_NS = 20;
   localparam int T_CAS_NS = 50;
   localparam int T_RP_NS = 60;
   localparam int T_CSR_NS = 10;
   localparam int T_RAS_REF_NS = 80;
   localparam int T_REFI_NS = 15600;
   localparam logic [7:0] T_RCD_CYC =
      8'((T_RCD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [7:0] T_CAS_CYC =
      8'((T_CAS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [7:0] T_RP_CYC =
      8'((T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [7:0] T_CSR_CYC =
      8'((T_CSR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [7:0] T_RAS_REF_CYC =
      8'((T_RAS_REF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [10:0] T_REFI_CYC = 11'(T_REFI_NS / CLK_PERIOD_NS);

   // ---------------------------------------------------------------
   // configuration register layout
   // ---------------------------------------------------------------
   localparam int CFG_W = 16;
   localparam int CFG_PAGE_LSB = 0;
   localparam int CFG_ILV_BIT = 2;
   localparam logic [15:0] CFG_RESET = 16'h0000;
   localparam logic [1:0] PAGE_512 = 2'h0;
   localparam logic [1:0] PAGE_2K = 2'h3;

   // ---------------------------------------------------------------
   // address widths
   // ---------------------------------------------------------------
   localparam int ADDR_W = 26;
   localparam int DADDR_W = 11;
   localparam int BANKS = 4;
   localparam logic [1:0] BURST_LAST = 2'h3;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_RAS = 3'h1,
      ST_CAS = 3'h3,
      ST_ACK = 3'h2,
      ST_PAGE = 3'h6,
      ST_PRE = 3'h7,
      ST_REFC = 3'h5,
      ST_REFR = 3'h4
   } dch_state_t;

endpackage

// File: rtl/dch_addr_mux.sv
// folds processor address into row, column and bank select
`timescale 1ns/1ps
module dch_addr_mux (
   // latched processor address
   input wire logic [dch_pkg::ADDR_W-1:0] addr,
   // configuration
   input wire logic [1:0] page_size_sel,
   input wire logic interleave,
   // dram address parts
   output logic [dch_pkg::DADDR_W-1:0] row,
   output logic [dch_pkg::DADDR_W-1:0] col,
   output logic [1:0] bank
);
   import dch_pkg::*;

   logic [3:0] width;
   logic [4:0] col_lsb;
   logic [4:0] row_lsb;
   logic [4:0] bank_lsb;
   logic [ADDR_W-1:0] col_sh;
   logic [ADDR_W-1:0] row_sh;
   logic [ADDR_W-1:0] bank_sh;

   always_comb begin
      // 9, 10 or 11 address bits per density class
      if (page_size_sel == PAGE_512) begin
         width = 4'h9;
      end else if (page_size_sel == PAGE_2K) begin
         width = 4'hb;
      end else begin
         width = 4'ha;
      end
      col_lsb = interleave ? 5'h03 : 5'h02;
      row_lsb = col_lsb + 5'(width);
      bank_lsb = row_lsb + 5'(width);
      col_sh = addr >> col_lsb;
      row_sh = addr >> row_lsb;
      bank_sh = addr >> bank_lsb;
      // interleaved pairs only use the upper select bit
      bank = interleave ? {bank_sh[0], 1'b0} : bank_sh[1:0];
   end

   // ---------------------------------------------------------------
   // mask unused upper address lines
   // ---------------------------------------------------------------
   for (genvar i = 0; i < DADDR_W; i++) begin : g_mask
      assign col[i] = (4'(i) < width) ? col_sh[i] : 1'b0;
      assign row[i] = (4'(i) < width) ? row_sh[i] : 1'b0;
   end

endmodule

// File: rtl/dch_refresh_timer.sv
// interval timer that requests cas-before-ras refresh
`timescale 1ns/1ps
module dch_refresh_timer (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   input wire logic clk_en,
   // handshake with the sequencer
   input wire logic ref_done,
   output logic ref_req
);
   import dch_pkg::*;

   typedef struct packed {
      logic [10:0] cnt;
      logic req;
   } dch_ref_t;

   dch_ref_t s_q;
   dch_ref_t s_d;

   always_comb begin
      s_d = s_q;
      if (ref_done) begin
         s_d.req = 1'b0;
      end
      if (s_q.cnt == 11'h000) begin
         s_d.cnt = T_REFI_CYC - 11'h001;
         s_d.req = 1'b1;
      end else begin
         s_d.cnt = s_q.cnt - 11'h001;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         s_q <= '0;
      end else if (clk_en) begin
         s_q <= s_d;
      end
   end

   assign ref_req = s_q.req;

endmodule

// File: rtl/dch_ctrl.sv
// dram controller: bus capture, sequencer, refresh and data path
`timescale 1ns/1ps
//
// Notes on behaviour
// - address is latched internally while the address strobe is low
// - a transaction starts only when the address decoder selects dram
// - cycle type comes from read, write and burst lines
// - acknowledge and read capture return when the access is far enough
// - acknowledge and read capture are tri-state outputs
// - row setup/hold, ras-cas delay, column setup, we setup are sequenced
// - data path steers transceivers or bus exchangers
// - column field starts at the same address bit for every dram size
// - 256k parts use 9-bit row and column from the fixed bit fields
// - 1M parts use 10-bit row and column from the fixed bit fields
// - 4M parts use 11-bit row and column from the fixed bit fields
// - non-interleaved bank select is the two bits above the row field
// - bank select picks one ras, or a ras pair when interleaved
// - bank select three picks ras 3, or ras pair 3:2 when interleaved
// - one to four banks, non-interleaved or two-way interleaved
// - single, page-mode and four-word burst transfers are served
// - page comparator lets a same-row access skip the row strobe
// - refresh is cas-before-ras, paced by an internal timer
// - configuration is 16 bits, write-only, all fields updated per write
// - bits 1:0 select page size 512, 1K, 1K or 2K
// - bit 2 selects interleaved operation with bus exchangers
module dch_ctrl (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   input wire logic clk_en,
   // processor bus
   input wire logic [31:0] ad_in,
   input wire logic ale_n,
   input wire logic rd_n,
   input wire logic wr_n,
   input wire logic burst_hint_n,
   // address decoder
   input wire logic dram_sel,
   // configuration write port
   input wire logic cfg_wr,
   input wire logic [dch_pkg::CFG_W-1:0] cfg_wdata,
   // handshake to processor
   output logic ack_n_o,
   output logic ack_n_oe,
   output logic read_capture_enable_n_o,
   output logic read_capture_enable_n_oe,
   // dram control
   output logic [dch_pkg::DADDR_W-1:0] dram_addr,
   output logic [dch_pkg::BANKS-1:0] ras_n,
   output logic [dch_pkg::BANKS-1:0] cas_n,
   output logic we_n,
   // data path
   output logic dp_oe_n,
   output logic dp_to_cpu,
   output logic dp_lane,
   output logic dp_exchanger
);
   import dch_pkg::*;

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      dch_state_t st;
      logic [7:0] cnt;
      logic [ADDR_W-1:0] addr;
      logic [CFG_W-1:0] cfg;
      logic is_wr;
      logic is_burst;
      logic done;
      logic [1:0] words;
      logic [DADDR_W-1:0] open_row;
      logic [1:0] open_bank;
      logic [DADDR_W-1:0] dram_addr;
      logic [BANKS-1:0] ras_n;
      logic [BANKS-1:0] cas_n;
      logic we_n;
      logic ack_n;
      logic rce_n;
      logic dp_oe_n;
      logic dp_to_cpu;
      logic dp_lane;
   } dch_ctrl_t;

   localparam dch_ctrl_t CTRL_RESET = '{
      st: ST_IDLE,
      cnt: 8'h00,
      addr: '0,
      cfg: CFG_RESET,
      is_wr: 1'b0,
      is_burst: 1'b0,
      done: 1'b0,
      words: 2'h0,
      open_row: '0,
      open_bank: 2'h0,
      dram_addr: '0,
      ras_n: 4'hf,
      cas_n: 4'hf,
      we_n: 1'b1,
      ack_n: 1'b1,
      rce_n: 1'b1,
      dp_oe_n: 1'b1,
      dp_to_cpu: 1'b0,
      dp_lane: 1'b0
   };

   dch_ctrl_t s_q;
   dch_ctrl_t s_d;

   // ---------------------------------------------------------------
   // ras decode per bank select
   // ---------------------------------------------------------------
   function automatic logic [BANKS-1:0] ras_mask(
      input logic [1:0] bank,
      input logic ilv
   );
      logic [BANKS-1:0] m;
      m = 4'h0;
      if (ilv) begin
         m = bank[1] ? 4'hc : 4'h3;
      end else begin
         m[bank] = 1'b1;
      end
      return m;
   endfunction

   // ---------------------------------------------------------------
   // address folding and refresh timer
   // ---------------------------------------------------------------
   logic [DADDR_W-1:0] row;
   logic [DADDR_W-1:0] col;
   logic [1:0] bank;
   logic ilv;
   logic ref_req;
   logic ref_done;

   assign ilv = s_q.cfg[CFG_ILV_BIT];

   dch_addr_mux u_mux (
      .addr(s_q.addr),
      .page_size_sel(s_q.cfg[CFG_PAGE_LSB +: 2]),
      .interleave(ilv),
      .row(row),
      .col(col),
      .bank(bank)
   );

   dch_refresh_timer u_ref (
      .core_clk(core_clk),
      .rst(rst),
      .clk_en(clk_en),
      .ref_done(ref_done),
      .ref_req(ref_req)
   );

   assign ref_done = (s_q.st == ST_REFR) && (s_q.cnt == 8'h00);

   // ---------------------------------------------------------------
   // request detection
   // ---------------------------------------------------------------
   logic strobe;
   logic req;
   logic page_hit;

   assign strobe = !rd_n || !wr_n;
   // only once the address phase is over and dram is decoded
   assign req = dram_sel && strobe && ale_n && !s_q.done;
   assign page_hit = (row == s_q.open_row) && (bank == s_q.open_bank);

   // ---------------------------------------------------------------
   // cycle type decode, shared by the idle and open-page paths
   // ---------------------------------------------------------------
   typedef struct packed {
      logic is_wr;
      logic is_burst;
      logic near;
   } dch_cyc_t;

   function automatic dch_cyc_t decode_cycle(
      input logic rd_l,
      input logic wr_l,
      input logic hint_l
   );
      dch_cyc_t c;
      c.is_wr = !wr_l;
      // hint line means burst on reads, same page on writes
      c.is_burst = !rd_l && !hint_l;
      c.near = !wr_l && !hint_l;
      return c;
   endfunction

   dch_cyc_t cyc;

   assign cyc = decode_cycle(rd_n, wr_n, burst_hint_n);

   // ---------------------------------------------------------------
   // sequencer
   // ---------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      s_d.ack_n = 1'b1;
      s_d.rce_n = 1'b1;
      if (s_q.cnt != 8'h00) begin
         s_d.cnt = s_q.cnt - 8'h01;
      end
      if (!ale_n) begin
         s_d.addr = ad_in[ADDR_W-1:0];
      end
      if (cfg_wr) begin
         s_d.cfg = cfg_wdata;
      end
      if (!strobe) begin
         s_d.done = 1'b0;
      end
      unique case (s_q.st)
         ST_IDLE: begin
            s_d.ras_n = 4'hf;
            s_d.cas_n = 4'hf;
            s_d.dp_oe_n = 1'b1;
            if (ref_req) begin
               s_d.cas_n = 4'h0;
               s_d.we_n = 1'b1;
               s_d.cnt = T_CSR_CYC;
               s_d.st = ST_REFC;
            end else if (req) begin
               // row address goes out a cycle ahead of ras
               s_d.dram_addr = row;
               s_d.open_row = row;
               s_d.open_bank = bank;
               s_d.is_wr = cyc.is_wr;
               s_d.is_burst = cyc.is_burst;
               s_d.words = 2'h0;
               s_d.we_n = wr_n;
               s_d.cnt = T_RCD_CYC;
               s_d.st = ST_RAS;
            end
         end
         ST_RAS: begin
            s_d.ras_n = ~ras_mask(s_q.open_bank, ilv);
            if (s_q.cnt == 8'h00) begin
               s_d.cnt = T_CAS_CYC;
               s_d.st = ST_CAS;
            end
         end
         ST_CAS: begin
            // first cycle is column set-up, cas falls after it
            s_d.dram_addr = col;
            s_d.dp_oe_n = 1'b0;
            s_d.dp_to_cpu = !s_q.is_wr;
            s_d.dp_lane = s_q.addr[2];
            if (s_q.cnt != T_CAS_CYC) begin
               s_d.cas_n = 4'h0;
            end
            if (s_q.cnt == 8'h00) begin
               s_d.rce_n = s_q.is_wr;
               s_d.ack_n = s_q.is_burst && (s_q.words != BURST_LAST);
               s_d.st = ST_ACK;
            end
         end
         ST_ACK: begin
            s_d.cas_n = 4'hf;
            s_d.done = !s_q.is_burst || (s_q.words == BURST_LAST);
            if (s_q.is_burst && (s_q.words != BURST_LAST)) begin
               // next word of the quad, page stays open
               s_d.words = s_q.words + 2'h1;
               s_d.addr[3:2] = s_q.addr[3:2] + 2'h1;
               s_d.cnt = T_CAS_CYC;
               s_d.st = ST_CAS;
            end else if (s_q.is_burst) begin
               // close the row after a refill
               s_d.dp_oe_n = 1'b1;
               s_d.cnt = T_RP_CYC;
               s_d.st = ST_PRE;
            end else begin
               s_d.dp_oe_n = 1'b1;
               s_d.we_n = 1'b1;
               s_d.st = ST_PAGE;
            end
         end
         ST_PAGE: begin
            if (req && (page_hit || cyc.near)) begin
               s_d.is_wr = cyc.is_wr;
               s_d.is_burst = cyc.is_burst;
               s_d.words = 2'h0;
               s_d.we_n = wr_n;
               s_d.cnt = T_CAS_CYC;
               s_d.st = ST_CAS;
            end else if (req || ref_req) begin
               s_d.cnt = T_RP_CYC;
               s_d.st = ST_PRE;
            end
         end
         ST_PRE: begin
            s_d.ras_n = 4'hf;
            s_d.cas_n = 4'hf;
            s_d.we_n = 1'b1;
            s_d.dp_oe_n = 1'b1;
            if (s_q.cnt == 8'h00) begin
               s_d.st = ST_IDLE;
            end
         end
         ST_REFC: begin
            if (s_q.cnt == 8'h00) begin
               s_d.ras_n = 4'h0;
               s_d.cnt = T_RAS_REF_CYC;
               s_d.st = ST_REFR;
            end
         end
         ST_REFR: begin
            if (s_q.cnt == 8'h00) begin
               s_d.ras_n = 4'hf;
               s_d.cas_n = 4'hf;
               s_d.open_bank = 2'h0;
               s_d.cnt = T_RP_CYC;
               s_d.st = ST_PRE;
            end
         end
      endcase
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         s_q <= CTRL_RESET;
      end else if (clk_en) begin
         s_q <= s_d;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign ack_n_o = s_q.ack_n;
   assign read_capture_enable_n_o = s_q.rce_n;
   // shared handshake lines, driven only while dram is addressed
   assign ack_n_oe = dram_sel && strobe;
   assign read_capture_enable_n_oe = dram_sel && strobe;
   assign dram_addr = s_q.dram_addr;
   assign ras_n = s_q.ras_n;
   assign cas_n = s_q.cas_n;
   assign we_n = s_q.we_n;
   assign dp_oe_n = s_q.dp_oe_n;
   assign dp_to_cpu = s_q.dp_to_cpu;
   assign dp_lane = s_q.dp_lane;
   assign dp_exchanger = ilv;

endmodule

// File: verification/dch_ctrl_chk.sv
// port assertions for the dram controller
`timescale 1ns/1ps
module dch_ctrl_chk (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // processor side
   input wire logic rd_n,
   input wire logic dram_sel,
   input wire logic ack_n_o,
   input wire logic ack_n_oe,
   input wire logic read_capture_enable_n_o,
   input wire logic read_capture_enable_n_oe,
   // dram side
   input wire logic [dch_pkg::BANKS-1:0] ras_n,
   input wire logic [dch_pkg::BANKS-1:0] cas_n,
   input wire logic we_n,
   input wire logic dp_to_cpu,
   input wire logic dp_exchanger
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   AST_OE_FLOAT: assert property (!dram_sel |->
      !ack_n_oe && !read_capture_enable_n_oe) else $error("oe while idle");
   AST_OE_DRIVE: assert property (dram_sel && !rd_n |->
      ack_n_oe && read_capture_enable_n_oe) else $error("oe missing");
   AST_ACK_SEL: assert property (!ack_n_o |-> dram_sel)
      else $error("ack without select");
   AST_ACK_PULSE: assert property ($fell(ack_n_o) |=> ack_n_o)
      else $error("ack longer than one cycle");
   AST_RCD: assert property ($fell(cas_n[0]) && ras_n != 4'hf |->
      $past(ras_n, 3) != 4'hf) else $error("ras to cas too short");
   AST_CBR: assert property ($fell(ras_n[0]) && cas_n == 4'h0 |->
      $past(cas_n) == 4'h0) else $error("refresh not cas first");
   AST_WE: assert property ($fell(cas_n[0]) && !we_n |-> !$past(we_n))
      else $error("we setup missing");
   AST_NI_ONE: assert property (!dp_exchanger && $past(ras_n) == 4'hf
      && ras_n != 4'hf && cas_n == 4'hf |-> $onehot(~ras_n))
      else $error("more than one ras");
   AST_IL_PAIR: assert property (dp_exchanger && $past(ras_n) == 4'hf
      && ras_n != 4'hf && cas_n == 4'hf |-> ras_n == 4'hc || ras_n == 4'h3)
      else $error("ras pair wrong");
   AST_RCE_DIR: assert property (!read_capture_enable_n_o |->
      dp_to_cpu && !rd_n) else $error("capture on non-read");
endmodule

bind dch_ctrl dch_ctrl_chk i_chk (.core_clk(core_clk), .rst(rst),
   .rd_n(rd_n), .dram_sel(dram_sel), .ack_n_o(ack_n_o),
   .ack_n_oe(ack_n_oe), .read_capture_enable_n_o(read_capture_enable_n_o),
   .read_capture_enable_n_oe(read_capture_enable_n_oe), .ras_n(ras_n),
   .cas_n(cas_n), .we_n(we_n), .dp_to_cpu(dp_to_cpu),
   .dp_exchanger(dp_exchanger));

// File: verification/dch_dram_model.sv
// passive dram bank model that records strobed addresses
`timescale 1ns/1ps
module dch_dram_model (
   // clock
   input wire logic core_clk,
   // dram pins
   input wire logic [dch_pkg::DADDR_W-1:0] dram_addr,
   input wire logic [dch_pkg::BANKS-1:0] ras_n,
   input wire logic [dch_pkg::BANKS-1:0] cas_n,
   input wire logic we_n,
   // captured values
   output logic [dch_pkg::DADDR_W-1:0] row_q,
   output logic [dch_pkg::DADDR_W-1:0] col_q,
   output logic [dch_pkg::BANKS-1:0] bank_q,
   output logic wr_q,
   output int opens
);
   logic [dch_pkg::BANKS-1:0] ras_p = 4'hf;
   logic [dch_pkg::BANKS-1:0] cas_p = 4'hf;
   initial opens = 0;
   always @(posedge core_clk) begin
      // row opened by ras fall with cas high
      if (ras_p == 4'hf && ras_n != 4'hf && cas_n == 4'hf) begin
         row_q <= dram_addr;
         bank_q <= ras_n;
         opens <= opens + 1;
      end
      if (cas_p == 4'hf && cas_n != 4'hf && ras_n != 4'hf) begin
         col_q <= dram_addr;
         wr_q <= !we_n;
      end
      ras_p <= ras_n;
      cas_p <= cas_n;
   end
endmodule

// File: verification/dch_ctrl_tb.sv
// self-checking bench for the dram controller
`timescale 1ns/1ps
module dch_ctrl_tb;
   import dch_pkg::*;
   typedef struct {
      logic [2:0] cfg;
      logic [1:0] bank;
      logic [10:0] rowv;
      logic [10:0] colv;
      logic [3:0] ras;
   } dch_row_t;
   logic core_clk = 1'b0;
   logic rst, clk_en, ale_n, rd_n, wr_n, burst_hint_n, dram_sel, cfg_wr;
   logic [31:0] ad_in;
   logic [15:0] cfg_wdata;
   logic ack_n_o, ack_n_oe, rce_n, rce_oe, we_n, dp_oe_n, dp_to_cpu;
   logic dp_lane, dp_exchanger, wr_q;
   logic [10:0] dram_addr, row_q, col_q;
   logic [3:0] ras_n, cas_n, bank_q, path;
   int opens, miscompares, checks_done, rces, n, o;
   dch_row_t tbl [7];
   always #5 core_clk = ~core_clk;
   dch_ctrl i_dut (.core_clk(core_clk), .rst(rst), .clk_en(clk_en),
      .ad_in(ad_in), .ale_n(ale_n), .rd_n(rd_n), .wr_n(wr_n),
      .burst_hint_n(burst_hint_n), .dram_sel(dram_sel), .cfg_wr(cfg_wr),
      .cfg_wdata(cfg_wdata), .ack_n_o(ack_n_o), .ack_n_oe(ack_n_oe),
      .read_capture_enable_n_o(rce_n), .read_capture_enable_n_oe(rce_oe),
      .dram_addr(dram_addr), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
      .dp_oe_n(dp_oe_n), .dp_to_cpu(dp_to_cpu), .dp_lane(dp_lane),
      .dp_exchanger(dp_exchanger));
   dch_dram_model i_mem (.core_clk(core_clk), .dram_addr(dram_addr),
      .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .row_q(row_q),
      .col_q(col_q), .bank_q(bank_q), .wr_q(wr_q), .opens(opens));
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic chk_v(input string what, input logic [10:0] exp,
         input logic [10:0] got);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   function automatic logic [25:0] mk(input dch_row_t r);
      int cw;
      int lsb;
      logic [1:0] b;
      cw = (r.cfg[1:0] == 2'h0) ? 9 : (r.cfg[1:0] == 2'h3) ? 11 : 10;
      lsb = r.cfg[2] ? 3 : 2;
      b = r.cfg[2] ? {1'b0, r.bank[1]} : r.bank;
      mk = 26'(r.colv) << lsb | 26'(r.rowv) << (lsb + cw)
         | 26'(b) << (lsb + 2 * cw);
   endfunction
   task automatic set_cfg(input logic [2:0] c);
      @(negedge core_clk);
      cfg_wdata = {13'h0000, c};
      cfg_wr = 1'b1;
      @(negedge core_clk);
      cfg_wr = 1'b0;
   endtask
   task automatic access(input logic [25:0] a, input logic wr,
         input logic hint);
      int k;
      rces = 0;
      @(negedge core_clk);
      ad_in = {6'h00, a};
      ale_n = 1'b0;
      @(negedge core_clk);
      ale_n = 1'b1;
      dram_sel = 1'b1;
      rd_n = wr;
      wr_n = !wr;
      burst_hint_n = !hint;
      for (k = 0; k < 150; k++) begin
         @(negedge core_clk);
         if (rce_n === 1'b0) rces++;
         if (ack_n_o === 1'b0) break;
      end
      if (k == 150) begin
         miscompares++;
         give_verdict();
      end
      path = {ack_n_oe, dp_oe_n, dp_to_cpu, dp_lane};
      // strobes stand over the edge that samples the acknowledge
      @(negedge core_clk);
      rd_n = 1'b1;
      wr_n = 1'b1;
      dram_sel = 1'b0;
      burst_hint_n = 1'b1;
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      rst = 1'b1;
      clk_en = 1'b1;
      ad_in = 32'h0000_0000;
      {ale_n, rd_n, wr_n, burst_hint_n} = 4'hf;
      dram_sel = 1'b0;
      cfg_wr = 1'b0;
      cfg_wdata = 16'h0000;
      tbl = '{'{3'h0, 2'h0, 11'h0a5, 11'h123, 4'he},
         '{3'h1, 2'h1, 11'h2c3, 11'h3f0, 4'hd},
         '{3'h2, 2'h2, 11'h155, 11'h2aa, 4'hb},
         '{3'h3, 2'h3, 11'h7ff, 11'h401, 4'h7},
         '{3'h4, 2'h0, 11'h1f0, 11'h00f, 4'hc},
         '{3'h5, 2'h2, 11'h3c3, 11'h111, 4'h3},
         '{3'h7, 2'h3, 11'h6a6, 11'h5a5, 4'h3}};
      repeat (4) @(negedge core_clk);
      chk_v("reset pins", 11'h7ff, {ras_n, cas_n, we_n, ack_n_o, dp_oe_n});
      $display("reset test done");
      rst = 1'b0;
      foreach (tbl[i]) begin
         set_cfg(tbl[i].cfg);
         access(mk(tbl[i]), 1'b0, 1'b0);
         chk_v("row", tbl[i].rowv, row_q);
         chk_v("col", tbl[i].colv, col_q);
         chk_v("ras", 11'(tbl[i].ras), 11'(bank_q));
         chk_v("rce", 11'h001, 11'(rces));
         chk_v("path", {7'h00, 3'h5, tbl[i].cfg[2] ? 1'b0 : tbl[i].colv[0]},
            11'(path));
         chk_v("exchanger", 11'(tbl[i].cfg[2]), 11'(dp_exchanger));
         $display("table row %0d done", i);
      end
      n = 0;
      @(negedge core_clk);
      rd_n = 1'b0;
      repeat (20) begin
         @(negedge core_clk);
         if (ack_n_o === 1'b0 || ack_n_oe !== 1'b0 || rce_n === 1'b0
            || rce_oe !== 1'b0) n++;
      end
      rd_n = 1'b1;
      chk_v("unselected", 11'h000, 11'(n));
      $display("unselected test done");
      set_cfg(3'h0);
      access(mk(tbl[0]), 1'b1, 1'b0);
      chk_v("write we", 11'h001, 11'(wr_q));
      chk_v("write rce", 11'h000, 11'(rces));
      chk_v("write path", 11'h009, 11'(path));
      o = opens;
      access(mk(tbl[0]), 1'b1, 1'b1);
      access(mk(tbl[0]), 1'b0, 1'b0);
      chk_v("page opens", 11'(o), 11'(opens));
      $display("page test done");
      access(mk(tbl[0]), 1'b0, 1'b1);
      chk_v("burst rce", 11'h004, 11'(rces));
      access(mk(tbl[0]), 1'b0, 1'b0);
      chk_v("reopen", 11'(o + 1), 11'(opens));
      $display("burst test done");
      n = 0;
      while (n < 1700 && !(cas_n === 4'h0 && ras_n === 4'hf)) begin
         @(negedge core_clk);
         n++;
      end
      chk_v("refresh", 11'h001, 11'(n < 1700));
      $display("refresh test done");
      give_verdict();
   end
endmodule
